/* File: rtl/swm_pkg.sv */
// Shared constants, register map and carrier types of the single-wire reset/presence master
package swm_pkg;

	// Clock and timing figures
	localparam int CLK_PERIOD_NS    = 10;
	localparam int CNT_W            = 20;
	localparam int LATENCY_MAX_NS   = 1090;
	localparam int LATENCY_MAX_CYC  = LATENCY_MAX_NS / CLK_PERIOD_NS;
	localparam int MRESET_MAX_NS    = 1635;
	localparam int MRESET_MAX_CYC   = MRESET_MAX_NS / CLK_PERIOD_NS;
	localparam int SHORT_SAMPLE_NS  = 8000;
	localparam int SHORT_SAMPLE_CYC = (SHORT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RSTL_BASE_NS     = 440000;
	localparam int RSTL_STEP_NS     = 8000;
	localparam int MSP_BASE_NS      = 60000;
	localparam int MSP_STEP_NS      = 2000;
	localparam int OD_SHIFT         = 3;

	// Command codes
	localparam logic [7:0] CMD_MASTER_RESET = 8'hF0;
	localparam logic [7:0] CMD_RESET_PULSE  = 8'hB4;

	// Register byte offsets
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_CONFIG   = 8'h08;
	localparam logic [7:0] REG_TIMING   = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] REG_RD_PTR   = 8'h18;
	localparam logic [7:0] REG_PTR_DATA = 8'h1C;

	// Interrupt bit positions
	localparam int IRQ_W          = 4;
	localparam int IRQ_CYCLE_DONE = 0;
	localparam int IRQ_PRESENCE   = 1;
	localparam int IRQ_SHORT      = 2;
	localparam int IRQ_MRESET     = 3;

	typedef logic [CNT_W-1:0] cnt_t;

	// Master status, bit 0 is line_busy
	typedef struct packed {
		logic cmd_refused;
		logic branch_direction;
		logic triplet_second_bit;
		logic single_bit_result;
		logic reset_occurred;
		logic short_detected;
		logic presence_detected;
		logic line_busy;
	} status_t;

	// Master configuration, bit 0 is overdrive_speed_select
	typedef struct packed {
		logic strong_pullup_enable;
		logic line_power_down;
		logic active_pullup_enable;
		logic overdrive_speed_select;
	} config_t;

	// Port timing codes, bits 3:0 are reset_low_time
	typedef struct packed {
		logic       weak_pullup_resistance;
		logic [3:0] recovery_time;
		logic [3:0] write_one_low_time;
		logic [3:0] write_zero_low_time;
		logic [3:0] presence_sample_time;
		logic [3:0] reset_low_time;
	} timing_t;

	localparam int CFG_W = $bits(config_t);
	localparam int TIM_W = $bits(timing_t);

	// Reset values
	localparam status_t STATUS_RESET = 8'h08;
	localparam status_t STATUS_MR    = 8'h08;
	localparam config_t CONFIG_RESET = 4'h0;
	localparam timing_t TIMING_RESET = 21'h066666;

	// Phase length in cycles from base, step and code; overdrive divides by eight
	function automatic cnt_t phase_cycles(input cnt_t base, input cnt_t step, input logic [3:0] code,
		input logic od);
		cnt_t full;
		full = base + cnt_t'(step * cnt_t'(code));
		return od ? (full >> OD_SHIFT) : full;
	endfunction : phase_cycles

endpackage : swm_pkg

/* File: rtl/swm_sync_edge.sv */
// Two-flop synchroniser with rising-edge detect on the settled copy
`timescale 1ns/1ps
`default_nettype none
module swm_sync_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Asynchronous input
	input  wire logic d,
	// Synchronised level and edge
	output logic      q,
	output logic      rise
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// Synchroniser chain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			last_ff <= 1'b1;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	// Edge seen only on the second and third flops
	assign q    = sync_ff;
	assign rise = sync_ff & ~last_ff;

endmodule : swm_sync_edge
`default_nettype wire

/* File: rtl/swm_reset_presence.sv */
// Single-wire master: master reset and reset/presence-detect commands
// Operation
// RULE1 - Master reset command returns every internal state machine to idle.
// RULE2 - Master reset aborts any line cycle; line released within 1.09 us.
// RULE3 - Master reset completes within 1.635 us and never stalls the host.
// RULE4 - Master reset sets reset-occurred flag and clears all other status flags.
// RULE5 - Master reset clears speed, active pullup, power-down and strong pullup bits.
// RULE6 - Master reset restores all port timing codes to power-on defaults.
// RULE7 - Host follows a master reset with a reset pulse command.
// RULE8 - Reset pulse command drives reset/presence cycle using current speed and timing.
// RULE9 - Line sampled at short and presence points after low phase, flags updated.
// RULE10 - Reset pulse refused and discarded while line busy flag is set.
// RULE11 - Line busy held for twice reset-low time; command ends within that.
// RULE12 - Reset pulse line activity begins within 1.09 us of acknowledge edge.
// RULE13 - Accepted reset pulse points read pointer at master status register.
// RULE14 - Presence and short flags set when line sampled low at their points.
`timescale 1ns/1ps
`default_nettype none
module swm_reset_presence
	import swm_pkg::*;
#(
	parameter cnt_t RSTL_BASE_CYC = cnt_t'((RSTL_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
	parameter cnt_t RSTL_STEP_CYC = cnt_t'((RSTL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
	parameter cnt_t MSP_BASE_CYC  = cnt_t'((MSP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
	parameter cnt_t MSP_STEP_CYC  = cnt_t'((MSP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [31:0] bus_rdata,
	// Host serial clock and command answer
	input  wire logic        scl,
	output logic             cmd_ack,
	// Open-drain line
	input  wire logic        line_in,
	output logic             line_out,
	output logic             line_oe_n,
	// Pullup and power controls
	output logic             active_pullup_on,
	output logic             strong_pullup_on,
	output logic             line_powered_down,
	output logic             weak_pullup_sel,
	// Interrupt
	output logic             irq
);

	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_RECOVER} state_t;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers

	logic [1:0] rst_sync_ff;
	logic       rst_n;
	logic       scl_rise;
	logic       line_s;

	// Asynchronous assert, two-flop release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	swm_sync_edge u_scl_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    (scl),
		.q    (),
		.rise (scl_rise)
	);

	swm_sync_edge u_line_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    (line_in),
		.q    (line_s),
		.rise ()
	);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Control state

	state_t          state_ff,   nxt_state;
	cnt_t            cnt_ff,     nxt_cnt;
	cnt_t            rstl_ff,    nxt_rstl;
	cnt_t            msp_ff,     nxt_msp;
	cnt_t            si_ff,      nxt_si;
	status_t         status_ff,  nxt_status;
	config_t         cfg_ff,     nxt_cfg;
	timing_t         tim_ff,     nxt_tim;
	logic            pend_mr_ff, nxt_pend_mr;
	logic            pend_rp_ff, nxt_pend_rp;
	logic            ack_ff,     nxt_ack;
	logic [7:0]      rd_ptr_ff,  nxt_rd_ptr;
	logic            oe_n_ff,    nxt_oe_n;
	logic            apu_on_ff,  nxt_apu_on;
	logic [IRQ_W-1:0] events;
	logic            exec_mr;
	logic            exec_rp;
	logic            cmd_wr;

	// Commands execute on the synchronised rising edge of the acknowledge clock
	assign exec_mr = pend_mr_ff & scl_rise;
	assign exec_rp = pend_rp_ff & scl_rise;
	assign cmd_wr  = bus_wr && (bus_addr == REG_CMD);

	// Next state of commands, line cycle, status and configuration
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_rstl    = rstl_ff;
		nxt_msp     = msp_ff;
		nxt_si      = si_ff;
		nxt_status  = status_ff;
		nxt_cfg     = cfg_ff;
		nxt_tim     = tim_ff;
		nxt_pend_mr = pend_mr_ff;
		nxt_pend_rp = pend_rp_ff;
		nxt_ack     = ack_ff;
		nxt_rd_ptr  = rd_ptr_ff;
		events      = '0;
		// Register writes
		if (bus_wr) begin
			case (bus_addr)
				REG_CMD: begin
					if (bus_wdata[7:0] == CMD_MASTER_RESET) begin
						nxt_ack                = 1'b1;
						nxt_pend_mr            = 1'b1;
						nxt_pend_rp            = 1'b0;
						nxt_status.cmd_refused = 1'b0;
					end else if (bus_wdata[7:0] == CMD_RESET_PULSE && status_ff.line_busy) begin
						nxt_ack                = 1'b0; // [RULE10]
						nxt_status.cmd_refused = 1'b1; // [RULE10]
					end else if (bus_wdata[7:0] == CMD_RESET_PULSE) begin
						nxt_ack                = 1'b1;
						nxt_pend_rp            = 1'b1;
						nxt_pend_mr            = 1'b0;
						nxt_status.cmd_refused = 1'b0;
						nxt_rd_ptr             = REG_STATUS; // [RULE13]
					end else begin
						nxt_ack                = 1'b0;
						nxt_status.cmd_refused = 1'b1;
					end
				end
				REG_CONFIG: nxt_cfg    = config_t'(bus_wdata[CFG_W-1:0]);
				REG_TIMING: nxt_tim    = timing_t'(bus_wdata[TIM_W-1:0]);
				REG_RD_PTR: nxt_rd_ptr = bus_wdata[7:0];
				default:    ;
			endcase
		end
		// Line cycle sequencer
		unique case (state_ff)
			ST_IDLE: begin
				if (exec_rp) begin
					nxt_pend_rp               = 1'b0;
					nxt_state                 = ST_LOW; // [RULE12]
					nxt_cnt                   = '0;
					nxt_status.reset_occurred = 1'b0;
					// Current speed and timing codes apply [RULE8]
					nxt_rstl = phase_cycles(RSTL_BASE_CYC, RSTL_STEP_CYC, tim_ff.reset_low_time,
						cfg_ff.overdrive_speed_select);
					nxt_msp  = phase_cycles(MSP_BASE_CYC, MSP_STEP_CYC, tim_ff.presence_sample_time,
						cfg_ff.overdrive_speed_select);
					nxt_si   = phase_cycles(cnt_t'(SHORT_SAMPLE_CYC), '0, 4'h0,
						cfg_ff.overdrive_speed_select);
				end
			end
			ST_LOW: begin
				nxt_cnt = cnt_ff + cnt_t'(1);
				if (cnt_ff == rstl_ff - cnt_t'(1)) begin
					nxt_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				nxt_cnt = cnt_ff + cnt_t'(1);
				// Short and presence sample points after the low phase [RULE9]
				if (cnt_ff == rstl_ff + si_ff) begin
					nxt_status.short_detected = ~line_s; // [RULE14]
					events[IRQ_SHORT]         = ~line_s;
				end
				if (cnt_ff == rstl_ff + msp_ff) begin
					nxt_status.presence_detected = ~line_s; // [RULE14]
					events[IRQ_PRESENCE]         = ~line_s;
				end
				if (cnt_ff == cnt_t'(rstl_ff << 1) - cnt_t'(1)) begin
					nxt_state                 = ST_IDLE; // [RULE11]
					events[IRQ_CYCLE_DONE]    = 1'b1;
				end
			end
		endcase
		// Master reset overrides the sequencer, pending commands, status, configuration, timing and events in the same cycle
		if (exec_mr) begin
			nxt_state   = ST_IDLE; // [RULE1] [RULE2]
			nxt_cnt     = '0;
			nxt_pend_mr = 1'b0;
			nxt_pend_rp = 1'b0;
			nxt_status  = STATUS_MR; // [RULE4]
			nxt_cfg     = CONFIG_RESET; // [RULE5]
			nxt_tim     = TIMING_RESET; // [RULE6]
			events      = '0;
			events[IRQ_MRESET] = 1'b1; // [RULE3]
		end
		nxt_status.line_busy = (nxt_state != ST_IDLE); // [RULE11]
		nxt_oe_n             = (nxt_state != ST_LOW);
		nxt_apu_on           = nxt_cfg.active_pullup_enable && (nxt_state == ST_RECOVER);
	end

	// Control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= ST_IDLE;
			cnt_ff     <= '0;
			rstl_ff    <= '0;
			msp_ff     <= '0;
			si_ff      <= '0;
			status_ff  <= STATUS_RESET;
			cfg_ff     <= CONFIG_RESET;
			tim_ff     <= TIMING_RESET;
			pend_mr_ff <= 1'b0;
			pend_rp_ff <= 1'b0;
			ack_ff     <= 1'b0;
			rd_ptr_ff  <= REG_STATUS;
			oe_n_ff    <= 1'b1;
			apu_on_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			rstl_ff    <= nxt_rstl;
			msp_ff     <= nxt_msp;
			si_ff      <= nxt_si;
			status_ff  <= nxt_status;
			cfg_ff     <= nxt_cfg;
			tim_ff     <= nxt_tim;
			pend_mr_ff <= nxt_pend_mr;
			pend_rp_ff <= nxt_pend_rp;
			ack_ff     <= nxt_ack;
			rd_ptr_ff  <= nxt_rd_ptr;
			oe_n_ff    <= nxt_oe_n;
			apu_on_ff  <= nxt_apu_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Read port and interrupts

	logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
	logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
	logic             irq_ff,      nxt_irq;
	logic [31:0]      rdata_ff,    nxt_rdata;
	logic [7:0]       eff_addr;

	// Register value at a byte offset
	function automatic logic [31:0] reg_value(input logic [7:0] addr);
		case (addr)
			REG_STATUS:   return {24'h0, status_ff};
			REG_CONFIG:   return {28'h0, cfg_ff};
			REG_TIMING:   return {11'h0, tim_ff};
			REG_IRQ_STAT: return {28'h0, irq_stat_ff};
			REG_IRQ_MASK: return {28'h0, irq_mask_ff};
			REG_RD_PTR:   return {24'h0, rd_ptr_ff};
			default:      return 32'h0;
		endcase
	endfunction : reg_value

	assign eff_addr = (bus_addr == REG_PTR_DATA) ? rd_ptr_ff : bus_addr;

	// Read data for one cycle, sticky events with set over read clear
	always_comb begin
		nxt_rdata    = bus_rd ? reg_value(eff_addr) : 32'h0;
		nxt_irq_stat = irq_stat_ff;
		if (bus_rd && eff_addr == REG_IRQ_STAT) begin
			nxt_irq_stat = '0;
		end
		nxt_irq_stat = nxt_irq_stat | events;
		nxt_irq_mask = (bus_wr && bus_addr == REG_IRQ_MASK) ? bus_wdata[IRQ_W-1:0] : irq_mask_ff;
		nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
	end

	// Read and interrupt registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff    <= 32'h0;
			irq_stat_ff <= '0;
			irq_mask_ff <= '0;
			irq_ff      <= 1'b0;
		end else begin
			rdata_ff    <= nxt_rdata;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			irq_ff      <= nxt_irq;
		end
	end

	// Outputs
	assign bus_rdata         = rdata_ff;
	assign cmd_ack           = ack_ff;
	assign line_out          = 1'b0;
	assign line_oe_n         = oe_n_ff;
	assign active_pullup_on  = apu_on_ff;
	assign strong_pullup_on  = cfg_ff.strong_pullup_enable;
	assign line_powered_down = cfg_ff.line_power_down;
	assign weak_pullup_sel   = tim_ff.weak_pullup_resistance;
	assign irq               = irq_ff;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Assertions

	logic [CNT_W:0] busy_len_ff;

	// Length of the current or last busy stretch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_ff <= '0;
		end else if (status_ff.line_busy && !$past(status_ff.line_busy)) begin
			busy_len_ff <= (CNT_W+1)'(1);
		end else if (status_ff.line_busy) begin
			busy_len_ff <= busy_len_ff + (CNT_W+1)'(1);
		end
	end

	a_mr_line_release: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
		exec_mr |=> line_oe_n [*8])
		else $error("line still driven after master reset");
	a_mr_idle_state: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
		exec_mr |=> (state_ff == ST_IDLE) && !pend_rp_ff && !pend_mr_ff)
		else $error("state machine not idle after master reset");
	a_mr_quick_done: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
		exec_mr |-> ##[1:2] (irq_stat_ff[IRQ_MRESET] && !status_ff.line_busy))
		else $error("master reset not complete in time");
	a_mr_status_flags: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		exec_mr |=> status_ff == STATUS_MR)
		else $error("status flags wrong after master reset");
	a_mr_config_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		exec_mr |=> (cfg_ff == CONFIG_RESET) && !strong_pullup_on && !line_powered_down)
		else $error("configuration not cleared by master reset");
	a_mr_timing_default: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
		exec_mr |=> tim_ff == TIMING_RESET)
		else $error("timing codes not restored by master reset");
	a_rp_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
		(cmd_wr && bus_wdata[7:0] == CMD_RESET_PULSE && status_ff.line_busy && !exec_mr)
		|=> !cmd_ack && status_ff.cmd_refused && !pend_rp_ff)
		else $error("reset pulse accepted while line busy");
	a_rp_line_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
		exec_rp |-> ##[1:2] (!line_oe_n && status_ff.line_busy))
		else $error("reset low phase did not start in time");
	a_rp_low_phase: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
		exec_rp |=> (rstl_ff == phase_cycles(RSTL_BASE_CYC, RSTL_STEP_CYC,
			$past(tim_ff.reset_low_time), $past(cfg_ff.overdrive_speed_select))))
		else $error("reset low time not taken from current settings");
	a_rp_busy_length: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		($fell(status_ff.line_busy) && !$past(exec_mr)) |-> busy_len_ff == {rstl_ff, 1'b0})
		else $error("busy stretch not twice reset low time");
	a_rp_read_ptr: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
		(cmd_wr && bus_wdata[7:0] == CMD_RESET_PULSE && !status_ff.line_busy) |=> rd_ptr_ff == REG_STATUS)
		else $error("read pointer not on status after reset pulse");
	a_presence_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
		(state_ff == ST_RECOVER && cnt_ff == rstl_ff + msp_ff && !line_s && !exec_mr)
		|=> status_ff.presence_detected ##1 irq_stat_ff[IRQ_PRESENCE])
		else $error("presence not flagged on low sample");
	a_short_sample: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
		(state_ff == ST_RECOVER && cnt_ff == rstl_ff + si_ff && !exec_mr)
		|=> status_ff.short_detected == !$past(line_s))
		else $error("short flag not updated at sample point");

	c_rp_cycle: cover property (@(posedge clk) disable iff (!rst_n) exec_rp);
	c_presence_seen: cover property (@(posedge clk) disable iff (!rst_n) $rose(status_ff.presence_detected));
	c_busy_refused: cover property (@(posedge clk) disable iff (!rst_n) $rose(status_ff.cmd_refused));
	c_mr_abort: cover property (@(posedge clk) disable iff (!rst_n) exec_mr && state_ff == ST_LOW);

endmodule : swm_reset_presence
`default_nettype wire

/* File: dv/swm_line_slave.sv */
// Behavioural slave on the single-wire line, answers a reset with a presence pulse
`timescale 1ns/1ps
`default_nettype none
module swm_line_slave (
	// Clock
	input  wire logic       clk,
	// Line level and behaviour: 0 absent, 1 presence, 2 line shorted
	input  wire logic       line,
	input  wire logic [1:0] mode,
	// Pull-down request onto the line
	output logic            pull
);
	int low_cnt   = 0; // Known from time zero so the line never starts unknown
	int pulse_cnt = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Long low seen, then release: pull low 40 cycles from the next cycle
	always_ff @(posedge clk) begin
		low_cnt <= line ? 0 : low_cnt + 1;
		if (line && low_cnt >= 64 && mode == 2'd1) begin
			pulse_cnt <= 40;
		end else if (pulse_cnt > 0) begin
			pulse_cnt <= pulse_cnt - 1;
		end
	end

	// A shorted line stays low whatever the master does
	assign pull = (mode == 2'd2) || (pulse_cnt > 0);
endmodule : swm_line_slave
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the master reset and reset/presence commands
`timescale 1ns/1ps
`default_nettype none
module testbench
	import swm_pkg::*;
;
	localparam int RB = 1000;
	localparam int RS = 4;
	localparam int MB = 20;
	localparam int MS = 2;

	logic        clk;
	logic        reset_n;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [31:0] bus_rdata;
	logic        scl;
	logic        cmd_ack;
	logic        line_out;
	logic        line_oe_n;
	logic        apu_on;
	logic        spu_on;
	logic        pdn_on;
	logic        wpu_sel;
	logic        irq;
	logic        slave_pull;
	logic [1:0]  slave_mode;
	wire logic   line;
	int          fail_count;
	int          checked;
	logic [31:0] rd;

	// Open-drain wire with pull-up
	assign line = ((line_oe_n === 1'b0 && line_out === 1'b0) || slave_pull) ? 1'b0 : 1'b1;

	swm_reset_presence #(.RSTL_BASE_CYC(cnt_t'(RB)), .RSTL_STEP_CYC(cnt_t'(RS)), .MSP_BASE_CYC(cnt_t'(MB)),
		.MSP_STEP_CYC(cnt_t'(MS))) dut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .scl(scl),
		.cmd_ack(cmd_ack), .line_in(line), .line_out(line_out), .line_oe_n(line_oe_n),
		.active_pullup_on(apu_on), .strong_pullup_on(spu_on), .line_powered_down(pdn_on),
		.weak_pullup_sel(wpu_sel), .irq(irq));

	swm_line_slave slave (.clk(clk), .line(line), .mode(slave_mode), .pull(slave_pull));

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Register port cycles
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clk);
		bus_wr    <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clk);
		bus_rd   <= 1'b0;
		#1 d = bus_rdata;
	endtask : bus_read

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
		bus_read(a, rd);
		chk(rd & m, e, w);
	endtask : rd_chk

	// Command write, answer checked in the following cycle
	task automatic cmd(input logic [7:0] code, input logic ack);
		bus_write(REG_CMD, {24'h000000, code});
		#1 chk({31'h0, cmd_ack}, {31'h0, ack}, "command answer");
	endtask : cmd

	// Acknowledge edge, then bounded wait for the line enable to reach a level
	task automatic scl_go(input logic want);
		int n;
		n = 0;
		scl = 1'b1;
		fork
			#62.5 scl = 1'b0;
		join_none
		while (line_oe_n !== want && n < LATENCY_MAX_CYC) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, line_oe_n}, {31'h0, want}, "line activity latency");
		#62.5;
	endtask : scl_go

	function automatic int rcyc(input int code, input logic od);
		return od ? ((RB + RS * code) >> 3) : (RB + RS * code);
	endfunction : rcyc

	// One reset/presence cycle with refusal, timing, flags and interrupt checks
	task automatic pulse(input logic [1:0] mode, input logic [3:0] cfg, input int code, input logic [3:0] fl);
		realtime t0;
		int      r;
		int      n;
		r = rcyc(code, cfg[0]);
		slave_mode = mode;
		bus_write(REG_TIMING, 32'h00066660 | code);
		bus_write(REG_CONFIG, {28'h0, cfg});
		cmd(CMD_RESET_PULSE, 1'b1);
		scl_go(1'b0);
		// Start of the low phase is the edge before the trailing half scl period
		t0 = $realtime - 62.5;
		cmd(CMD_RESET_PULSE, 1'b0);
		rd_chk(REG_STATUS, 32'h81, 32'h81, "refused while busy");
		rd_chk(REG_RD_PTR, 32'hFF, 32'h04, "read pointer");
		rd_chk(REG_PTR_DATA, 32'h01, 32'h01, "busy via pointer");
		n = 0;
		while (line_oe_n !== 1'b1 && n < 4096) begin
			@(posedge clk);
			n++;
		end
		n = int'(($realtime - t0) / 10.0);
		chk(32'(n > r + 1 || n < r - 1), 32'h0, "reset low length");
		repeat (3) @(posedge clk);
		chk({31'h0, apu_on}, {31'h0, cfg[1]}, "active pullup in release");
		repeat (r - 10) @(posedge clk);
		rd_chk(REG_STATUS, 32'h01, 32'h01, "busy before end");
		repeat (16) @(posedge clk);
		rd_chk(REG_STATUS, 32'h0F, {28'h0, fl}, "flags after cycle");
		chk({31'h0, irq}, 32'h0, "masked interrupt");
		bus_write(REG_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1, "unmasked interrupt");
		rd_chk(REG_IRQ_STAT, 32'h07, {29'h0, fl[2:1], 1'b1}, "interrupt events");
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "interrupt cleared by read");
		bus_write(REG_IRQ_MASK, 32'h0);
	endtask : pulse

	// Bound on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		scl = 1'b0;
		slave_mode = 2'd1;
		fail_count = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h08, "status after reset");
		rd_chk(REG_TIMING, 32'hFFFFFFFF, 32'h066666, "timing after reset");
		rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped offset");
		bus_write(REG_CONFIG, 32'hF);
		bus_write(REG_TIMING, 32'h1FFFFF);
		bus_write(8'h20, 32'hFFFFFFFF);
		rd_chk(REG_CONFIG, 32'hFFFFFFFF, 32'hF, "config written");
		chk({29'h0, spu_on, pdn_on, wpu_sel}, 32'h7, "pullup controls set");
		// Master reset from a fully configured state, host keeps the order
		cmd(CMD_MASTER_RESET, 1'b1);
		scl_go(1'b1);
		repeat (MRESET_MAX_CYC) @(posedge clk);
		rd_chk(REG_CONFIG, 32'hFFFFFFFF, 32'h0, "config cleared");
		rd_chk(REG_TIMING, 32'hFFFFFFFF, 32'h066666, "timing defaults");
		rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h08, "status after master reset");
		chk({29'h0, spu_on, pdn_on, wpu_sel}, 32'h0, "pullup controls cleared");
		rd_chk(REG_IRQ_STAT, 32'h08, 32'h08, "master reset event");
		// Presence, short, absent, overdrive, other reset-low code
		pulse(2'd1, 4'h2, 6, 4'h2);
		pulse(2'd2, 4'h0, 10, 4'h6);
		pulse(2'd0, 4'h0, 6, 4'h0);
		pulse(2'd1, 4'h3, 6, 4'h2);
		// Master reset aborts a running cycle
		slave_mode = 2'd1;
		cmd(CMD_RESET_PULSE, 1'b1);
		scl_go(1'b0);
		repeat (50) @(posedge clk);
		cmd(CMD_MASTER_RESET, 1'b1);
		scl_go(1'b1);
		repeat (MRESET_MAX_CYC) @(posedge clk);
		rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h08, "status after abort");
		repeat (300) @(posedge clk);
		chk({31'h0, line_oe_n}, 32'h1, "line stays released");
		pulse(2'd1, 4'h0, 6, 4'h2);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
